// file: hw/pll_power_defs.svh
// Notes on behaviour
// - Status bit 2 reads the live level of the crystal input pin.
// - Status bit 1 reads PLL lock; one locked, zero on fallback clock.
// - Status bit 0 sets when lock falls; cleared by writing one.
// - PLL source update needs key 0xAA before and 0x55 after.
// - Power control update needs key 0x01 before and 0xF4 after.
// - Reference select: 00 low-power, 01 precision, 10 crystal, 11 reserved.
// - Power bit 7 enables precision input, also needs high-voltage enable.
// - Power bit 6 enables the crystal oscillator circuit.
// - Clearing power bit 5 stops the PLL and PLL-clocked timers.
// - Power bits 3, 4, 5 are one after reset and on wake-up.
// - PLL powers down only when bits 3, 4, 5 clear together.
// - Peripherals power down only when bit 3 clears in same write.
// - With peripherals down, LIN wake-up and wake-up timer stay alive.
// - Clearing bit 3 halts core clock until a wake-up event.
// - Core divider divides the PLL clock by two to the field value.
// - Power control resets to 0x79.
// - PLL source select resets to 0x00.
// - Flash clock is PLL divided by 8 until lock.
// - PLL multiplies its reference by 625; internal oscillators divided by 4.
// - PLL locks within 2 ms after wake-up from an active source.
`ifndef PLL_POWER_DEFS_SVH
`define PLL_POWER_DEFS_SVH
`define OFS_PLL_STATUS      32'hFFFF0400
`define OFS_POW_PREKEY      32'hFFFF0404
`define OFS_POWER_CONTROL   32'hFFFF0408
`define OFS_POW_POSTKEY     32'hFFFF040C
`define OFS_PLL_PREKEY      32'hFFFF0410
`define OFS_PLL_SOURCE      32'hFFFF0414
`define OFS_PLL_POSTKEY     32'hFFFF0418
`define KEY_PLL_PRE         32'h000000AA
`define KEY_PLL_POST        32'h00000055
`define KEY_POW_PRE         32'h00000001
`define KEY_POW_POST        32'h000000F4
`define RST_POWER_CONTROL   8'h79
`define RST_PLL_SOURCE      8'h00
`define BIT_XTAL            2
`define BIT_LOCK            1
`define BIT_LOL             0
`define BIT_PREC_EN         7
`define BIT_XTAL_EN         6
`define BIT_PLL_ON          5
`define BIT_PERIPH_ON       4
`define BIT_CORE_ON         3
`define FALLBACK_DIV_LOG2   3
`define PLL_MULT            625
`define OSC_PREDIV          4
`define LOCK_TIME_US        2000
`define CLK_MHZ             100
`define LOCK_CYCLES         (`LOCK_TIME_US * `CLK_MHZ)
`endif

// file: hw/pll_power_pkg.sv
package pll_power_pkg;
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ARMED,
        KEY_PENDING
    } key_state_t;
    typedef enum logic [1:0] {
        SRC_LOW_POWER,
        SRC_PRECISION,
        SRC_CRYSTAL,
        SRC_RESERVED
    } ref_src_t;
endpackage

// file: hw/pll_power_ctrl.sv
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "pll_power_defs.svh"
module pll_power_ctrl #(
    parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [31:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_crystal_input_pin,
    input  wire logic        i_wakeup,
    input  wire logic        i_high_voltage_config_prec_en,
    output logic [1:0]       o_pll_ref_select,
    output logic             o_prec_osc_en,
    output logic             o_xtal_osc_en,
    output logic             o_pll_on,
    output logic             o_periph_on,
    output logic             o_core_on,
    output logic             o_lin_wakeup_alive,
    output logic             o_core_clk_en,
    output logic             o_flash_clk_en,
    output logic             o_pll_locked,
    output logic             o_lol_irq
);
    logic [7:0]                pow_q;
    logic [7:0]                pow_d;
    logic [1:0]                src_q;
    logic [1:0]                src_d;
    logic [7:0]                pow_stage_q;
    logic [1:0]                src_stage_q;
    pll_power_pkg::key_state_t pow_st_q;
    pll_power_pkg::key_state_t src_st_q;
    logic                      lol_q;
    logic                      lock_q;
    logic [31:0]               lock_cnt_q;
    logic [6:0]                div_cnt_q;
    logic                      xtal_q;
    logic                      ack_q;

    wire acc       = (i_avs_read | i_avs_write) & ~ack_q;
    wire wr        = i_avs_write & ~ack_q;
    wire full_word = (i_avs_byteenable == 4'hF);
    wire sel_sta   = (i_avs_address == `OFS_PLL_STATUS);
    wire sel_powk0 = (i_avs_address == `OFS_POW_PREKEY);
    wire sel_pow   = (i_avs_address == `OFS_POWER_CONTROL);
    wire sel_powk1 = (i_avs_address == `OFS_POW_POSTKEY);
    wire sel_srck0 = (i_avs_address == `OFS_PLL_PREKEY);
    wire sel_src   = (i_avs_address == `OFS_PLL_SOURCE);
    wire sel_srck1 = (i_avs_address == `OFS_PLL_POSTKEY);

    wire pow_pre_ok  = wr & sel_powk0 & full_word & (i_avs_writedata == `KEY_POW_PRE);
    wire pow_post_ok = wr & sel_powk1 & full_word & (i_avs_writedata == `KEY_POW_POST);
    wire src_pre_ok  = wr & sel_srck0 & full_word & (i_avs_writedata == `KEY_PLL_PRE);
    wire src_post_ok = wr & sel_srck1 & full_word & (i_avs_writedata == `KEY_PLL_POST);
    wire pow_commit  = (pow_st_q == pll_power_pkg::KEY_PENDING) & pow_post_ok;
    wire src_commit  = (src_st_q == pll_power_pkg::KEY_PENDING) & src_post_ok;

    // Power-down of periph needs core off, PLL needs both off
    wire       w_core   = pow_stage_q[`BIT_CORE_ON];
    wire       w_periph = pow_stage_q[`BIT_PERIPH_ON] | w_core;
    wire       w_pll    = pow_stage_q[`BIT_PLL_ON] | w_periph;
    wire [7:0] pow_fix  = {pow_stage_q[7:6], w_pll, w_periph, w_core, pow_stage_q[2:0]};

    always_comb begin
        pow_d = pow_q;
        if (pow_commit) begin
            pow_d = pow_fix;
        end
        if (i_wakeup) begin
            pow_d[`BIT_CORE_ON]   = 1'b1;
            pow_d[`BIT_PERIPH_ON] = 1'b1;
            pow_d[`BIT_PLL_ON]    = 1'b1;
        end
    end

    assign src_d = src_commit ? src_stage_q : src_q;

    // Key sequencers: pre-key arms, data stages, post-key commits
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pow_st_q    <= pll_power_pkg::KEY_IDLE;
            pow_stage_q <= 8'h00;
        end else if (wr) begin
            case (pow_st_q)
                pll_power_pkg::KEY_IDLE: begin
                    if (pow_pre_ok) begin
                        pow_st_q <= pll_power_pkg::KEY_ARMED;
                    end
                end
                pll_power_pkg::KEY_ARMED: begin
                    if (sel_pow) begin
                        pow_st_q    <= pll_power_pkg::KEY_PENDING;
                        pow_stage_q <= i_avs_writedata[7:0];
                    end else begin
                        pow_st_q <= pll_power_pkg::KEY_IDLE;
                    end
                end
                default: begin
                    pow_st_q <= pll_power_pkg::KEY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            src_st_q    <= pll_power_pkg::KEY_IDLE;
            src_stage_q <= 2'h0;
        end else if (wr) begin
            case (src_st_q)
                pll_power_pkg::KEY_IDLE: begin
                    if (src_pre_ok) begin
                        src_st_q <= pll_power_pkg::KEY_ARMED;
                    end
                end
                pll_power_pkg::KEY_ARMED: begin
                    if (sel_src) begin
                        src_st_q    <= pll_power_pkg::KEY_PENDING;
                        src_stage_q <= i_avs_writedata[1:0];
                    end else begin
                        src_st_q <= pll_power_pkg::KEY_IDLE;
                    end
                end
                default: begin
                    src_st_q <= pll_power_pkg::KEY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pow_q <= `RST_POWER_CONTROL;
            src_q <= 2'(`RST_PLL_SOURCE);
        end else begin
            pow_q <= pow_d;
            src_q <= src_d;
        end
    end

    // Lock model: counts lock time after PLL on or reference change
    wire pll_run  = pow_q[`BIT_PLL_ON];
    wire relock   = src_commit & (src_stage_q != src_q);
    wire lock_now = pll_run & ~relock & (lock_cnt_q >= LOCK_CYCLES - 1);
    wire lock_fall = lock_q & ~lock_now;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lock_cnt_q <= 32'h00000000;
            lock_q     <= 1'b0;
        end else begin
            if (!pll_run || relock) begin
                lock_cnt_q <= 32'h00000000;
            end else if (!lock_now) begin
                lock_cnt_q <= lock_cnt_q + 32'h00000001;
            end
            lock_q <= lock_now;
        end
    end

    wire lol_clr = wr & sel_sta & i_avs_byteenable[0] & i_avs_writedata[`BIT_LOL];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lol_q <= 1'b0;
        end else if (lock_fall) begin
            lol_q <= 1'b1;
        end else if (lol_clr) begin
            lol_q <= 1'b0;
        end
    end

    // Core clock divider: enable every 2^field cycles, fallback by 8
    wire [2:0] div_log2 = lock_q ? pow_q[2:0] : 3'(`FALLBACK_DIV_LOG2);
    wire [6:0] div_max  = 7'((8'h01 << div_log2) - 8'h01);
    wire       div_tick = (div_cnt_q >= div_max);
    wire [2:0] fl_mask  = 3'h7;
    wire       fl_tick  = lock_q | (div_cnt_q[2:0] == fl_mask);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_cnt_q      <= 7'h00;
            o_core_clk_en  <= 1'b0;
            o_flash_clk_en <= 1'b0;
        end else begin
            div_cnt_q      <= (div_tick | ~pll_run) ? 7'h00 : div_cnt_q + 7'h01;
            o_core_clk_en  <= pll_run & pow_q[`BIT_CORE_ON] & div_tick;
            o_flash_clk_en <= pll_run & pow_q[`BIT_PERIPH_ON] & fl_tick;
        end
    end

    // Pins are taken as synchronous; live level registered once
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            xtal_q <= 1'b0;
        end else begin
            xtal_q <= i_crystal_input_pin;
        end
    end

    wire [7:0]  sta_val = {5'h00, xtal_q, lock_q, lol_q};
    wire [31:0] rd_mux  = sel_sta ? {24'h000000, sta_val} :
                          sel_pow ? {24'h000000, pow_q} :
                          sel_src ? {30'h00000000, src_q} : 32'h00000000;

    // Avalon slave: one wait cycle, then waitrequest low for one cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_q             <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h00000000;
        end else begin
            ack_q             <= acc;
            o_avs_waitrequest <= ~acc;
            o_avs_readdata    <= rd_mux;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pll_ref_select   <= 2'h0;
            o_prec_osc_en      <= 1'b0;
            o_xtal_osc_en      <= 1'b0;
            o_pll_on           <= 1'b1;
            o_periph_on        <= 1'b1;
            o_core_on          <= 1'b1;
            o_lin_wakeup_alive <= 1'b1;
            o_pll_locked       <= 1'b0;
            o_lol_irq          <= 1'b0;
        end else begin
            o_pll_ref_select   <= (src_q == 2'h3) ? 2'h0 : src_q;
            o_prec_osc_en      <= pow_q[`BIT_PREC_EN] & i_high_voltage_config_prec_en;
            o_xtal_osc_en      <= pow_q[`BIT_XTAL_EN];
            o_pll_on           <= pow_q[`BIT_PLL_ON];
            o_periph_on        <= pow_q[`BIT_PERIPH_ON];
            o_core_on          <= pow_q[`BIT_CORE_ON];
            o_lin_wakeup_alive <= 1'b1;
            o_pll_locked       <= lock_q;
            o_lol_irq          <= lol_q;
        end
    end
endmodule

// file: verif/pll_power_ctrl_chk.sv
`timescale 1ns/1ps
`include "pll_power_defs.svh"
module pll_power_ctrl_chk (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_address,
    input wire logic [31:0] i_avs_writedata,
    input wire logic        i_wakeup,
    input wire logic        i_high_voltage_config_prec_en,
    input wire logic        o_prec_osc_en,
    input wire logic        o_pll_on,
    input wire logic        o_periph_on,
    input wire logic        o_core_on,
    input wire logic        o_core_clk_en,
    input wire logic        o_flash_clk_en,
    input wire logic        o_pll_locked,
    input wire logic        o_lol_irq
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    lol_set_a: assert property ($fell(o_pll_locked) |-> ##[0:1] o_lol_irq)
        else $error("lock loss not flagged");
    lol_hold_a: assert property (o_lol_irq && !(i_avs_write && i_avs_address == `OFS_PLL_STATUS
        && i_avs_writedata[0]) |=> o_lol_irq) else $error("flag dropped without clear");
    wake_set_a: assert property (i_wakeup |-> ##[1:2] (o_pll_on && o_periph_on && o_core_on))
        else $error("wake-up did not power up");
    pll_order_a: assert property (!o_pll_on |-> !o_core_on && !o_periph_on)
        else $error("pll off while core or peripherals on");
    periph_order_a: assert property (!o_periph_on |-> !o_core_on)
        else $error("peripherals off while core on");
    core_gate_a: assert property (!o_core_on [*2] |-> !o_core_clk_en)
        else $error("core clock runs while core off");
    flash_full_a: assert property (o_pll_locked [*2] ##0 o_periph_on |-> o_flash_clk_en)
        else $error("flash clock not full rate when locked");
    flash_slow_a: assert property (!o_pll_locked [*3] ##0 o_flash_clk_en |=> !o_flash_clk_en || o_pll_locked)
        else $error("flash clock too fast when unlocked");
    prec_gate_a: assert property (o_prec_osc_en |-> i_high_voltage_config_prec_en
        || $past(i_high_voltage_config_prec_en)) else $error("precision input on without enable");
endmodule
bind pll_power_ctrl pll_power_ctrl_chk u_pll_power_ctrl_chk (.i_clk, .i_rst, .i_avs_write, .i_avs_address,
    .i_avs_writedata, .i_wakeup, .i_high_voltage_config_prec_en, .o_prec_osc_en, .o_pll_on, .o_periph_on,
    .o_core_on, .o_core_clk_en, .o_flash_clk_en, .o_pll_locked, .o_lol_irq);

// file: verif/pll_power_ctrl_tb.sv
`timescale 1ns/1ps
`include "pll_power_defs.svh"
module pll_power_ctrl_tb;
    localparam int LK = 20;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [31:0] i_avs_address = 32'h0;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hF;
    logic        i_crystal_input_pin = 1'b0;
    logic        i_wakeup = 1'b0;
    logic        i_high_voltage_config_prec_en = 1'b0;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest, o_prec_osc_en, o_xtal_osc_en, o_pll_on, o_periph_on, o_core_on;
    logic        o_lin_wakeup_alive, o_core_clk_en, o_flash_clk_en, o_pll_locked, o_lol_irq;
    logic [1:0]  o_pll_ref_select;
    logic [31:0] q;
    int          failures = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          nc;
    int          nf;
    pll_power_ctrl #(.LOCK_CYCLES(LK)) u_pll_power_ctrl (.i_clk, .i_rst, .i_avs_address, .i_avs_read,
        .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
        .i_crystal_input_pin, .i_wakeup, .i_high_voltage_config_prec_en, .o_pll_ref_select, .o_prec_osc_en,
        .o_xtal_osc_en, .o_pll_on, .o_periph_on, .o_core_on, .o_lin_wakeup_alive, .o_core_clk_en,
        .o_flash_clk_en, .o_pll_locked, .o_lol_irq);
    always #5 i_clk = ~i_clk;
    task automatic summarize();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One bus access, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= !w;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic kw(input logic [31:0] pa, pk, ra, d, qa, qk);
        acc(1'b1, pa, pk);
        acc(1'b1, ra, d);
        acc(1'b1, qa, qk);
    endtask
    task automatic pow(input logic [31:0] d);
        kw(`OFS_POW_PREKEY, `KEY_POW_PRE, `OFS_POWER_CONTROL, d, `OFS_POW_POSTKEY, `KEY_POW_POST);
        repeat (2) @(posedge i_clk);
    endtask
    // Count core and flash clock enables over a window
    task automatic cnt(input int len);
        nc = 0;
        nf = 0;
        repeat (len) begin
            @(negedge i_clk);
            nc += int'(o_core_clk_en);
            nf += int'(o_flash_clk_en);
        end
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(`OFS_POWER_CONTROL, 32'h79);
        rd(`OFS_PLL_SOURCE, 32'h0);
        chk(32'({o_pll_ref_select, o_pll_on, o_periph_on, o_core_on}), 32'h7);
        repeat (LK + 5) @(posedge i_clk);
        rd(`OFS_PLL_STATUS, 32'h2);
        chk(32'(o_pll_locked), 32'h1);
        i_crystal_input_pin <= 1'b1;
        rd(`OFS_PLL_STATUS, 32'h6);
        i_crystal_input_pin <= 1'b0;
        kw(`OFS_PLL_PREKEY, `KEY_PLL_PRE, `OFS_PLL_SOURCE, 32'h3, `OFS_PLL_POSTKEY, `KEY_PLL_POST);
        @(posedge i_clk);
        rd(`OFS_PLL_SOURCE, 32'h3);
        chk(32'(o_pll_ref_select), 32'h0);
        for (int i = 0; i < 3; i++) begin
            kw(`OFS_PLL_PREKEY, `KEY_PLL_PRE, `OFS_PLL_SOURCE, i, `OFS_PLL_POSTKEY, `KEY_PLL_POST);
            @(posedge i_clk);
            rd(`OFS_PLL_SOURCE, i);
            chk(32'(o_pll_ref_select), i);
        end
        acc(1'b1, `OFS_PLL_SOURCE, 32'h1);
        kw(`OFS_PLL_PREKEY, 32'hAB, `OFS_PLL_SOURCE, 32'h1, `OFS_PLL_POSTKEY, `KEY_PLL_POST);
        kw(`OFS_PLL_PREKEY, `KEY_PLL_PRE, `OFS_PLL_SOURCE, 32'h1, `OFS_POW_PREKEY, `KEY_POW_PRE);
        acc(1'b1, `OFS_PLL_POSTKEY, `KEY_PLL_POST);
        rd(`OFS_PLL_SOURCE, 32'h2);
        acc(1'b1, 32'hFFFF041C, 32'hFF);
        rd(32'hFFFF041C, 32'h0);
        repeat (LK + 5) @(posedge i_clk);
        rd(`OFS_PLL_STATUS, 32'h3);
        chk(32'(o_lol_irq), 32'h1);
        acc(1'b1, `OFS_PLL_STATUS, 32'h0);
        rd(`OFS_PLL_STATUS, 32'h3);
        acc(1'b1, `OFS_PLL_STATUS, 32'h1);
        rd(`OFS_PLL_STATUS, 32'h2);
        pow(32'h68);
        rd(`OFS_POWER_CONTROL, 32'h78);
        pow(32'h58);
        rd(`OFS_POWER_CONTROL, 32'h78);
        pow(32'hB8);
        chk(32'({o_prec_osc_en, o_xtal_osc_en}), 32'h0);
        i_high_voltage_config_prec_en <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk(32'({o_prec_osc_en, o_xtal_osc_en}), 32'h2);
        cnt(64);
        chk(32'({nc[15:0], nf[15:0]}), 32'h00400040);
        pow(32'h7B);
        cnt(64);
        chk(32'({nc[15:0], nf[15:0]}), 32'h00080040);
        pow(32'h40);
        rd(`OFS_POWER_CONTROL, 32'h40);
        chk(32'({o_pll_on, o_periph_on, o_core_on, o_lin_wakeup_alive}), 32'h1);
        cnt(16);
        chk(32'(nc), 32'h0);
        @(posedge i_clk);
        i_wakeup <= 1'b1;
        @(posedge i_clk);
        i_wakeup <= 1'b0;
        repeat (3) @(posedge i_clk);
        cnt(8);
        chk(32'({nc[15:0], nf[15:0]}), 32'h00010001);
        rd(`OFS_PLL_STATUS, 32'h1);
        chk(32'(o_pll_locked), 32'h0);
        rd(`OFS_POWER_CONTROL, 32'h78);
        repeat (LK + 5) @(posedge i_clk);
        rd(`OFS_PLL_STATUS, 32'h3);
        summarize();
    end
endmodule
